// ===== bridge_predriver_timing_regs.v
// pre-driver timing registers with decode to clock-cycle durations
`timescale 1ns/1ns
`include "predrv_timing_defines.vh"

module bridge_predriver_timing_regs #(
  parameter CYC_W = 9
) (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // register port from the serial decoder, same clock
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // second on code, held in a register outside this block
  input wire [2:0] low_side_second_on_time,
  // decoded durations in ref_clk cycles
  output reg [CYC_W-1:0] low_side_second_on_cycles,
  output reg [CYC_W-1:0] high_side_off_cycles,
  output reg [CYC_W-1:0] low_side_off_cycles,
  output reg [CYC_W-1:0] high_side_first_on_cycles,
  output reg [CYC_W-1:0] low_side_first_on_cycles
);

  // register images; every bit is stored, spare ones included
  reg [7:0] off_phase_timing_r;
  reg [7:0] first_on_phase_timing_r;
  reg [7:0] off_phase_timing_nxt;
  reg [7:0] first_on_phase_timing_nxt;
  reg [7:0] reg_rdata_nxt;

  // next values of the decoded durations
  reg [CYC_W-1:0] low_side_second_on_nxt;
  reg [CYC_W-1:0] high_side_off_nxt;
  reg [CYC_W-1:0] low_side_off_nxt;
  reg [CYC_W-1:0] high_side_first_on_nxt;
  reg [CYC_W-1:0] low_side_first_on_nxt;

  // code fields of the two images
  wire [2:0] high_side_off_time;
  wire [2:0] low_side_off_time;
  wire [2:0] high_side_first_on_time;
  wire [2:0] low_side_first_on_time;

  // address decode, shared by the write and the read path
  wire off_phase_hit;
  wire first_on_hit;

  // true when the port address selects the given register
  function addr_match;
    input [3:0] addr;
    input [3:0] target;
    begin
      addr_match = (addr == target);
    end
  endfunction

  // pick the high or low three-bit code out of a register image
  function [2:0] code_field;
    input [7:0] image;
    input high;
    begin
      if (high)
        code_field = image[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
      else
        code_field = image[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
    end
  endfunction

  // long phases: base plus half-microsecond steps, converted to cycles
  function [CYC_W-1:0] long_cycles;
    input [2:0] code;
    integer ns;
    integer cyc;
    begin
      ns = `LONG_BASE_NS + code * `LONG_STEP_NS;
      cyc = ns / `CLK_PERIOD_NS;
      // 4.75 us is 475 cycles, so the default width holds every code
      long_cycles = cyc[CYC_W-1:0];
    end
  endfunction

  // first on phase is irregular (825 ns at code 4), so a table
  function [CYC_W-1:0] first_on_cycles;
    input [2:0] code;
    integer ns;
    integer cyc;
    begin
      case (code)
        3'h0: ns = `T1_CODE0_NS;
        3'h1: ns = `T1_CODE1_NS;
        3'h2: ns = `T1_CODE2_NS;
        3'h3: ns = `T1_CODE3_NS;
        3'h4: ns = `T1_CODE4_NS;
        3'h5: ns = `T1_CODE5_NS;
        3'h6: ns = `T1_CODE6_NS;
        default: ns = `T1_CODE7_NS;
      endcase
      // 375, 625, 825 and 1125 ns are not whole cycles; round up to keep the minimum
      cyc = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      first_on_cycles = cyc[CYC_W-1:0];
    end
  endfunction

  assign off_phase_hit = addr_match(reg_addr, `OFF_PHASE_ADDR);
  assign first_on_hit = addr_match(reg_addr, `FIRST_ON_ADDR);

  // spare bits 7 and 3 never reach the decoders
  assign high_side_off_time = code_field(off_phase_timing_r, 1'h1);
  assign low_side_off_time = code_field(off_phase_timing_r, 1'h0);
  assign high_side_first_on_time = code_field(first_on_phase_timing_r, 1'h1);
  assign low_side_first_on_time = code_field(first_on_phase_timing_r, 1'h0);

  // write decode; writes to other addresses are dropped
  always @* begin
    off_phase_timing_nxt = off_phase_timing_r;
    first_on_phase_timing_nxt = first_on_phase_timing_r;
    if (reg_wr && off_phase_hit)
      off_phase_timing_nxt = reg_wdata;
    if (reg_wr && first_on_hit)
      first_on_phase_timing_nxt = reg_wdata;
  end

  // read mux; unmapped addresses read zero
  always @* begin
    reg_rdata_nxt = 8'h00;
    if (off_phase_hit)
      reg_rdata_nxt = off_phase_timing_r;
    if (first_on_hit)
      reg_rdata_nxt = first_on_phase_timing_r;
  end

  // decoders, one per phase and side
  always @* begin
    low_side_second_on_nxt = long_cycles(low_side_second_on_time);
    high_side_off_nxt = long_cycles(high_side_off_time);
    low_side_off_nxt = long_cycles(low_side_off_time);
    high_side_first_on_nxt = first_on_cycles(high_side_first_on_time);
    low_side_first_on_nxt = first_on_cycles(low_side_first_on_time);
  end

  // register images
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // codes reset to 001, spare bits to zero
      off_phase_timing_r <= `OFF_PHASE_RESET;
      first_on_phase_timing_r <= `FIRST_ON_RESET;
    end else begin
      off_phase_timing_r <= off_phase_timing_nxt;
      first_on_phase_timing_r <= first_on_phase_timing_nxt;
    end
  end

  // read data is registered: it shows the previous cycle's address
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

  // each duration has its own flop, so the sequencer sees no glitch
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      low_side_second_on_cycles <= {CYC_W{1'h0}};
    end else begin
      low_side_second_on_cycles <= low_side_second_on_nxt;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      high_side_off_cycles <= {CYC_W{1'h0}};
    end else begin
      high_side_off_cycles <= high_side_off_nxt;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      low_side_off_cycles <= {CYC_W{1'h0}};
    end else begin
      low_side_off_cycles <= low_side_off_nxt;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      high_side_first_on_cycles <= {CYC_W{1'h0}};
    end else begin
      high_side_first_on_cycles <= high_side_first_on_nxt;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      low_side_first_on_cycles <= {CYC_W{1'h0}};
    end else begin
      low_side_first_on_cycles <= low_side_first_on_nxt;
    end
  end

endmodule

// ===== predrv_timing_defines.vh
// register offsets, field layout, reset values and phase durations
`ifndef PREDRV_TIMING_DEFINES_VH
`define PREDRV_TIMING_DEFINES_VH

`define OFF_PHASE_ADDR 4'hC
`define FIRST_ON_ADDR 4'hD
`define OFF_PHASE_RESET 8'h11
`define FIRST_ON_RESET 8'h11
`define HIGH_FIELD_MSB 6
`define HIGH_FIELD_LSB 4
`define LOW_FIELD_MSB 2
`define LOW_FIELD_LSB 0

// long phases (second on, off): 1.25 us base, 0.5 us step, in ns
`define LONG_BASE_NS 1250
`define LONG_STEP_NS 500
// first on phase table, in ns
`define T1_CODE0_NS 375
`define T1_CODE1_NS 500
`define T1_CODE2_NS 625
`define T1_CODE3_NS 750
`define T1_CODE4_NS 825
`define T1_CODE5_NS 1000
`define T1_CODE6_NS 1125
`define T1_CODE7_NS 1250
`define CLK_PERIOD_NS 10

`endif

// ===== pt_src.sv
// far-side source of the second on code
`timescale 1ns/1ns
module pt_src(input wire ref_clk,input wire [2:0] sel,
output reg [2:0] low_side_second_on_time);
always @(posedge ref_clk) low_side_second_on_time<=sel;
endmodule

// ===== pt_sva.sv
// assertions for the pre-driver timing registers
`timescale 1ns/1ns
module pt_chk #(parameter CYC_W=9)(input wire ref_clk,resetn,reg_wr,
input wire [3:0] reg_addr,input wire [7:0] reg_wdata,reg_rdata,
input wire [2:0] low_side_second_on_time,input wire [CYC_W-1:0]
low_side_second_on_cycles,high_side_off_cycles,low_side_off_cycles,
high_side_first_on_cycles,low_side_first_on_cycles);
int t[8]='{38,50,63,75,83,100,113,125};
wire c=reg_wr&&reg_addr==4'hC,d=reg_wr&&reg_addr==4'hD;
default clocking @(posedge ref_clk); endclocking
default disable iff(!resetn);
a_t2_decode:assert property($past(resetn)|->low_side_second_on_cycles==
125+50*$past(low_side_second_on_time))else $error("t2");
a_off_read:assert property(c##1!reg_wr&&reg_addr==4'hC
|=>reg_rdata==$past(reg_wdata,2))else $error("read C");
a_hi_off:assert property(c##1!c|=>high_side_off_cycles==
125+50*$past(reg_wdata[6:4],2))else $error("hi off");
a_lo_off:assert property(c##1!c|=>low_side_off_cycles==
125+50*$past(reg_wdata[2:0],2))else $error("lo off");
a_first_read:assert property(d##1!reg_wr&&reg_addr==4'hD
|=>reg_rdata==$past(reg_wdata,2))else $error("read D");
a_hi_first:assert property(d##1!d|=>high_side_first_on_cycles==
t[$past(reg_wdata[6:4],2)])else $error("hi first");
a_lo_first:assert property(d##1!d|=>low_side_first_on_cycles==
t[$past(reg_wdata[2:0],2)])else $error("lo first");
a_unmapped_read:assert property(reg_addr<4'hC
|=>reg_rdata==0)else $error("unmapped");
c_wr_off:cover property(c);
c_wr_first:cover property(d);
c_wr_other:cover property(reg_wr&&reg_addr==4'h0);
endmodule
bind bridge_predriver_timing_regs pt_chk #(.CYC_W(CYC_W)) chk(
.ref_clk(ref_clk),.resetn(resetn),.reg_wr(reg_wr),.reg_addr(reg_addr),
.reg_wdata(reg_wdata),.reg_rdata(reg_rdata),
.low_side_second_on_time(low_side_second_on_time),
.low_side_second_on_cycles(low_side_second_on_cycles),
.high_side_off_cycles(high_side_off_cycles),
.low_side_off_cycles(low_side_off_cycles),
.high_side_first_on_cycles(high_side_first_on_cycles),
.low_side_first_on_cycles(low_side_first_on_cycles));

// ===== tb.sv
// bench for the pre-driver timing registers
`timescale 1ns/1ns
module tb;
reg ref_clk=0,resetn=0,reg_wr=0;
reg [3:0] reg_addr=4'h0;
reg [2:0] sel=3'h0;
reg [7:0] reg_wdata=8'h00;
wire [7:0] reg_rdata;
wire [2:0] low_side_second_on_time;
wire [8:0] low_side_second_on_cycles,high_side_off_cycles,
low_side_off_cycles,high_side_first_on_cycles,low_side_first_on_cycles;
int failures=0,compares=0,t[8]='{38,50,63,75,83,100,113,125};
always #5 ref_clk=~ref_clk;
pt_src src(.*);
bridge_predriver_timing_regs uut(.ref_clk(ref_clk),.resetn(resetn),
.reg_addr(reg_addr),.reg_wr(reg_wr),.reg_wdata(reg_wdata),
.reg_rdata(reg_rdata),.low_side_second_on_time(low_side_second_on_time),
.low_side_second_on_cycles(low_side_second_on_cycles),
.high_side_off_cycles(high_side_off_cycles),
.low_side_off_cycles(low_side_off_cycles),
.high_side_first_on_cycles(high_side_first_on_cycles),
.low_side_first_on_cycles(low_side_first_on_cycles));
task chk(input logic [15:0] s,e);compares++;
if(s!==e) begin failures++;
$display("mismatch %0t seen %0h want %0h",$time,s,e);end endtask
task wr(input logic [3:0] a,input logic [7:0] v);
@(posedge ref_clk)#1{reg_addr,reg_wdata,reg_wr}={a,v,1'b1};
@(posedge ref_clk)#1 reg_wr=0;endtask
task rd(input logic [3:0] a,input logic [7:0] e);
@(posedge ref_clk)#1 reg_addr=a;
repeat(2)@(posedge ref_clk);#1 chk(reg_rdata,e);endtask
task final_report;$display("failures %0d compares %0d",failures,compares);
if(failures==0&&compares>0) $display("DONE - PASS");
else $display("DONE - FAIL");
$finish;endtask
initial begin repeat(20)@(posedge ref_clk);#1 resetn=1;
rd(4'hC,8'h11);
rd(4'hD,8'h11);
chk(high_side_off_cycles,175);
chk(low_side_off_cycles,175);
chk(high_side_first_on_cycles,50);
chk(low_side_first_on_cycles,50);
chk(low_side_second_on_cycles,125);
// spare bits set on purpose: they must not move any duration
for(int k=0;k<8;k++) begin sel=k[2:0];
wr(4'hC,{1'b1,k[2:0],1'b1,~k[2:0]});
wr(4'hD,{k[0],~k[2:0],1'b1,k[2:0]});
wr(4'h0,8'hFF);
rd(4'h0,8'h00);
chk(high_side_off_cycles,125+50*k);
chk(low_side_off_cycles,475-50*k);
chk(high_side_first_on_cycles,t[7-k]);
chk(low_side_first_on_cycles,t[k]);
chk(low_side_second_on_cycles,125+50*k);
rd(4'hC,{1'b1,k[2:0],1'b1,~k[2:0]});
rd(4'hD,{k[0],~k[2:0],1'b1,k[2:0]});
end
final_report;end
initial begin #9000 failures++;final_report;end
endmodule
